// ### bench/dts_check_monitor.sv
// Purpose: port checker for debug trigger and status
// Assumes: one clock, reset active low
// Notes:   bound to the top module below
`timescale 1ns/1ps
module dts_check_monitor #(
   parameter int DEPTH = dts_pkg::FIFO_DEPTH
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [2:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        cmp_a_hit,
   input wire logic        cmp_b_hit,
   input wire logic        data_b_hit,
   input wire logic        range_in,
   input wire logic        opcode_exec,
   input wire logic        bus_valid,
   input wire logic [15:0] capture_word,
   input wire logic        armed,
   input wire logic        trigger_out
);
   logic [7:0] setup_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         setup_reg <= 8'h00;
      else if (reg_wr && reg_addr == 3'h0 && !armed)
         setup_reg <= reg_wdata;
   end
   sequence s_ctl;
      reg_wr && reg_addr == 3'h2;
   endsequence
   sequence s_stat;
      reg_rd && reg_addr == 3'h1;
   endsequence
   a_setup_read: assert property (reg_rd && reg_addr == 3'h0 |=>
      reg_rdata == (setup_reg & 8'hCF)) else $error("setup readback");
   a_arm_set: assert property (s_ctl ##0 reg_wdata[7:6] == 2'h3
      |=> armed) else $error("arm not set");
   a_arm_stop: assert property (s_ctl ##0 reg_wdata[7:6] != 2'h3
      |=> !armed) else $error("arm not cleared");
   a_armed_flag_copy: assert property (s_stat |=>
      reg_rdata[5] == $past(armed)) else $error("armed flag");
   a_trig_run: assert property (!armed |=> !trigger_out)
      else $error("trigger while idle");
   a_end_trace: assert property (armed && setup_reg == 8'h00 &&
      cmp_a_hit && bus_valid |=> trigger_out && !armed) else $error("end");
   a_no_mode: assert property (setup_reg[3:0] > 4'h8 |->
      !trigger_out) else $error("trigger in unused mode");
   a_cnt_max: assert property (s_stat |=>
      reg_rdata[3:0] <= 4'(DEPTH)) else $error("count too big");
endmodule : dts_check_monitor
bind dts_debug_trigger_status dts_check_monitor #(.DEPTH(DEPTH))
   dts_check_inst (.*);

// ### bench/dts_debug_trigger_status_test.sv
// Purpose: self-checking bench for debug trigger and status
// Assumes: host model drives the register port
// Notes:   hit inputs change at rising edges
`timescale 1ns/1ps
module dts_debug_trigger_status_test;
   logic        clk = 1'h0;
   logic        rstn = 1'h0;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, d;
   logic        reg_wr, reg_rd, armed, trigger_out, seen = 1'h0;
   logic [5:0]  hits = 6'h00;
   logic [15:0] capture_word = 16'h0000;
   int          num_errors = 0, num_checks = 0, cycles = 0;
   initial begin
      forever #10 clk = ~clk;
   end
   dts_host_model dts_host_model_inst (.*);
   dts_debug_trigger_status dts_debug_trigger_status_inst (.*,
      .cmp_a_hit(hits[5]), .cmp_b_hit(hits[4]), .data_b_hit(hits[3]),
      .range_in(hits[2]), .opcode_exec(hits[1]), .bus_valid(hits[0]));
   always @(negedge clk) if (trigger_out === 1'h1) seen = 1'h1;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      dts_host_model_inst.wr(a, v);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      dts_host_model_inst.rd(a, v);
   endtask : rd
   task automatic stim(input logic [5:0] h, input logic [15:0] w);
      @(posedge clk);
      hits         <= h;
      capture_word <= w;
   endtask : stim
   task automatic t_regs();
      wr(3'h1, 8'hFF);
      rd(3'h1, d);
      check(d, 8'h00);
      wr(3'h0, 8'hFF);
      rd(3'h0, d);
      check(d, 8'hCF);
      rd(3'h7, d);
      check(d, 8'h00);
      $display("register test done");
   endtask : t_regs
   task automatic t_end();
      wr(3'h0, 8'h00);
      wr(3'h2, 8'hC0);
      for (int i = 0; i < 10; i++) begin
         stim(6'h01, 16'h0100 + 16'(i));
      end
      stim(6'h21, 16'hBEEF);
      stim(6'h00, 16'h0000);
      rd(3'h1, d);
      check(d, 8'h88);
      wr(3'h2, 8'hC0);
      rd(3'h1, d);
      check(d, 8'h20);
      wr(3'h0, 8'h07);
      rd(3'h0, d);
      check(d, 8'h00);
      wr(3'h2, 8'h00);
      @(negedge clk);
      check({7'h00, armed}, 8'h00);
      $display("end trace test done");
   endtask : t_end
   task automatic t_event();
      wr(3'h0, 8'h03);
      wr(3'h2, 8'hC0);
      for (int i = 0; i < 8; i++) begin
         stim(6'h11, {8'hA5, 8'h10 + 8'(i)});
      end
      stim(6'h00, 16'h0000);
      @(negedge clk);
      check({7'h00, armed}, 8'h00);
      rd(3'h1, d);
      check(d, 8'h48);
      rd(3'h3, d);
      check(d, 8'h00);
      rd(3'h3, d);
      rd(3'h4, d);
      check(d, 8'h10);
      rd(3'h4, d);
      check(d, 8'h11);
      check(8'(dts_host_model_inst.words_left), 8'h06);
      rd(3'h1, d);
      check(d, 8'h48);
      $display("event test done");
   endtask : t_event
   task automatic t_mode(input logic [7:0] su, input logic [5:0] s1, s2,
                         input logic tr, ar);
      wr(3'h0, su);
      wr(3'h2, 8'hC0);
      seen = 1'h0;
      stim(s1, 16'h1234);
      stim(s2, 16'h5678);
      stim(6'h00, 16'h0000);
      repeat (3) @(posedge clk);
      check({7'h00, seen}, {7'h00, tr});
      check({7'h00, armed}, {7'h00, ar});
      wr(3'h2, 8'h80);
   endtask : t_mode
   task automatic t_modes();
      t_mode(8'h00, 6'h21, 6'h00, 1'h1, 1'h0);
      t_mode(8'h01, 6'h11, 6'h00, 1'h1, 1'h0);
      t_mode(8'h02, 6'h21, 6'h11, 1'h1, 1'h0);
      t_mode(8'h02, 6'h11, 6'h00, 1'h0, 1'h1);
      t_mode(8'h05, 6'h29, 6'h00, 1'h1, 1'h0);
      t_mode(8'h05, 6'h21, 6'h00, 1'h0, 1'h1);
      t_mode(8'h06, 6'h21, 6'h00, 1'h1, 1'h0);
      t_mode(8'h06, 6'h29, 6'h00, 1'h0, 1'h1);
      t_mode(8'h07, 6'h05, 6'h00, 1'h1, 1'h0);
      t_mode(8'h07, 6'h01, 6'h00, 1'h0, 1'h1);
      t_mode(8'h08, 6'h01, 6'h00, 1'h1, 1'h0);
      t_mode(8'h08, 6'h05, 6'h00, 1'h0, 1'h1);
      t_mode(8'h80, 6'h21, 6'h00, 1'h0, 1'h1);
      t_mode(8'h80, 6'h23, 6'h00, 1'h1, 1'h0);
      t_mode(8'h41, 6'h11, 6'h00, 1'h1, 1'h1);
      for (int c = 9; c < 16; c++) begin
         t_mode(8'(c), 6'h3F, 6'h3B, 1'h0, 1'h1);
      end
      $display("mode test done");
   endtask : t_modes
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      t_regs();
      t_end();
      t_event();
      t_modes();
      complete_run();
   end
endmodule : dts_debug_trigger_status_test

// ### bench/dts_host_model.sv
// Purpose: debug host model on the register port
// Assumes: read data stand the cycle after the strobe
// Notes:   keeps its own tally of unread fifo words
`timescale 1ns/1ps
module dts_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic      [2:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   int words_left = 0;
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 13'h0000;
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      v = reg_rdata;
      if (a == 3'h4 && words_left > 0)
         words_left--;
      else if (a == 3'h1 && v[5] == 1'h0)
         words_left = int'(v[3:0]);
   endtask : rd
endmodule : dts_host_model

// ### verilog/dts_debug_trigger_status.sv
// Purpose: trigger selection, run control and status of bus capture
// Assumes: comparator hits, opcode execute and bus data come from
//          same-clock logic; fifo storage lives here, eight words
// Notes:   read data valid the cycle after the read strobe
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module dts_debug_trigger_status #(
   parameter int DEPTH = dts_pkg::FIFO_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        cmp_a_hit,
   input  wire logic        cmp_b_hit,
   input  wire logic        data_b_hit,
   input  wire logic        range_in,
   input  wire logic        opcode_exec,
   input  wire logic        bus_valid,
   input  wire logic [15:0] capture_word,
   output logic             armed,
   output logic             trigger_out
);
   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_s1_reg, rst_s2_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   wire logic rst_n = rst_s2_reg;

   // ---------------------------------------------------------------
   // registers and decode
   // ---------------------------------------------------------------
   logic [7:0]  setup_reg, setup_next;
   logic        en_reg, arm_reg, arm_next;
   logic [5:0]  ctl_low_reg;
   logic        af_reg, bf_reg, a_seen_reg;
   logic [3:0]  cnt_reg;
   logic [2:0]  wptr_reg, rptr_reg;
   logic [15:0] mem [DEPTH];
   logic [7:0]  rdata_reg;
   logic        trig_reg;

   wire logic wr_setup = reg_wr && reg_addr == dts_pkg::ADDR_TRIGGER_SETUP;
   wire logic wr_ctl   = reg_wr && reg_addr == dts_pkg::ADDR_CONTROL;
   wire logic rd_low   = reg_rd && reg_addr == dts_pkg::ADDR_FIFO_LOW;
   wire logic tag_sel  = setup_reg[dts_pkg::BIT_TRG_TYPE];
   wire logic [3:0] mode = setup_reg[3:0];
   wire logic start = wr_ctl && reg_wdata[dts_pkg::BIT_EN]
                      && reg_wdata[dts_pkg::BIT_ARM];

   // qualified comparator hits
   wire logic hit_a = cmp_a_hit && bus_valid && (!tag_sel || opcode_exec);
   wire logic hit_b = cmp_b_hit && bus_valid && (!tag_sel || opcode_exec);
   wire logic event_mode = mode == dts_pkg::DTS_EV_B ||
                           mode == dts_pkg::DTS_A_THEN_EV;
   wire logic begin_trace = setup_reg[dts_pkg::BIT_BEGIN] || event_mode;

   // trigger selection
   logic trig;
   always_comb begin
      case (mode)
         dts_pkg::DTS_A_ONLY:    trig = hit_a;
         dts_pkg::DTS_A_OR_B:    trig = hit_a || hit_b;
         dts_pkg::DTS_A_THEN_B:  trig = a_seen_reg && hit_b;
         dts_pkg::DTS_EV_B:      trig = hit_b;
         dts_pkg::DTS_A_THEN_EV: trig = a_seen_reg && hit_b;
         dts_pkg::DTS_A_AND_B:   trig = hit_a && data_b_hit;
         dts_pkg::DTS_A_NAND_B:  trig = hit_a && !data_b_hit;
         dts_pkg::DTS_INSIDE:    trig = bus_valid && range_in;
         dts_pkg::DTS_OUTSIDE:   trig = bus_valid && !range_in;
         default:                trig = 1'b0;
      endcase
   end

   // storage and run end
   wire logic run    = arm_reg && en_reg;
   logic      fired_reg;
   wire logic full   = cnt_reg == 4'(DEPTH);
   wire logic store  = run && (event_mode ? trig
                       : (begin_trace ? (fired_reg || trig) && bus_valid
                                      : bus_valid));
   wire logic end_run = run && (begin_trace ? (full ||
                        (store && cnt_reg == 4'(DEPTH - 1)))
                        : trig);
   wire logic [15:0] store_word = event_mode ?
                        {dts_pkg::RST_BYTE, capture_word[7:0]} :
                        capture_word;

   always_comb begin
      setup_next = setup_reg;
      if (wr_setup && !arm_reg)
         setup_next = reg_wdata & dts_pkg::SETUP_WMASK;
      arm_next = arm_reg;
      if (wr_ctl)
         arm_next = reg_wdata[dts_pkg::BIT_ARM] && reg_wdata[dts_pkg::BIT_EN];
      else if (end_run)
         arm_next = 1'b0;
   end

   // ---------------------------------------------------------------
   // control and status
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         setup_reg   <= dts_pkg::RST_BYTE;
         en_reg      <= 1'b0;
         arm_reg     <= 1'b0;
         ctl_low_reg <= 6'h00;
      end else begin
         setup_reg <= setup_next;
         arm_reg   <= arm_next;
         if (wr_ctl) begin
            en_reg      <= reg_wdata[dts_pkg::BIT_EN];
            ctl_low_reg <= reg_wdata[5:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         af_reg     <= 1'b0;
         bf_reg     <= 1'b0;
         a_seen_reg <= 1'b0;
         fired_reg  <= 1'b0;
      end else if (start) begin
         af_reg     <= 1'b0;
         bf_reg     <= 1'b0;
         a_seen_reg <= 1'b0;
         fired_reg  <= 1'b0;
      end else if (run) begin
         if (hit_a) af_reg <= 1'b1;
         if (hit_b) bf_reg <= 1'b1;
         if (hit_a) a_seen_reg <= 1'b1;
         if (trig)  fired_reg  <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // capture fifo
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= dts_pkg::CNT_ZERO;
         wptr_reg <= 3'h0;
         rptr_reg <= 3'h0;
      end else if (start) begin
         cnt_reg  <= dts_pkg::CNT_ZERO;
         wptr_reg <= 3'h0;
         rptr_reg <= 3'h0;
      end else if (store) begin
         wptr_reg <= wptr_reg + 3'h1;
         if (!full) cnt_reg <= cnt_reg + dts_pkg::CNT_ONE;
         rptr_reg <= full ? wptr_reg + 3'h1 : rptr_reg;
      end else if (rd_low && !run) begin
         rptr_reg <= rptr_reg + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (store)
         mem[wptr_reg] <= store_word;
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         dts_pkg::ADDR_TRIGGER_SETUP: rd_mux = setup_reg;
         dts_pkg::ADDR_STATUS_FLAGS:  rd_mux = {af_reg, bf_reg, run,
                                               1'b0, cnt_reg};
         dts_pkg::ADDR_CONTROL:       rd_mux = {en_reg, arm_reg,
                                               ctl_low_reg};
         dts_pkg::ADDR_FIFO_HIGH:     rd_mux = mem[rptr_reg][15:8];
         dts_pkg::ADDR_FIFO_LOW:      rd_mux = mem[rptr_reg][7:0];
         default:                     rd_mux = dts_pkg::RST_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= dts_pkg::RST_BYTE;
         trig_reg  <= 1'b0;
      end else begin
         rdata_reg <= reg_rd ? rd_mux : dts_pkg::RST_BYTE;
         trig_reg  <= run && trig;
      end
   end

   assign reg_rdata   = rdata_reg;
   assign armed       = arm_reg;
   assign trigger_out = trig_reg;
endmodule : dts_debug_trigger_status

// ### verilog/dts_pkg.sv
// Purpose: constants for the debug trigger and status block
// Assumes: 8-bit register port, one clock
// Notes:   register offsets are local choices
package dts_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_TRIGGER_SETUP = 3'h0;
   localparam logic [2:0] ADDR_STATUS_FLAGS  = 3'h1;
   localparam logic [2:0] ADDR_CONTROL       = 3'h2;
   localparam logic [2:0] ADDR_FIFO_HIGH     = 3'h3;
   localparam logic [2:0] ADDR_FIFO_LOW      = 3'h4;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_TRG_TYPE   = 7;
   localparam int BIT_BEGIN      = 6;
   localparam int BIT_AF         = 7;
   localparam int BIT_BF         = 6;
   localparam int BIT_ARMED_FLAG       = 5;
   localparam int BIT_EN         = 7;
   localparam int BIT_ARM        = 6;
   localparam logic [7:0] SETUP_WMASK = 8'hCF;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [3:0] CNT_ZERO    = 4'h0;
   localparam logic [3:0] CNT_ONE     = 4'h1;
   localparam int         FIFO_DEPTH  = 8;
   // ---------------------------------------------------------------
   // trigger modes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      DTS_A_ONLY    = 4'h0,
      DTS_A_OR_B    = 4'h1,
      DTS_A_THEN_B  = 4'h2,
      DTS_EV_B      = 4'h3,
      DTS_A_THEN_EV = 4'h4,
      DTS_A_AND_B   = 4'h5,
      DTS_A_NAND_B  = 4'h6,
      DTS_INSIDE    = 4'h7,
      DTS_OUTSIDE   = 4'h8
   } dts_mode_t;
   typedef enum logic [1:0] {
      DTS_IDLE = 2'h0,
      DTS_WAIT = 2'h1,
      DTS_FILL = 2'h2
   } dts_state_t;
endpackage : dts_pkg
